// ===== verilog/intc_consts.vh
// Constants of the prioritised interrupt controller: offsets, bits, timing.
// Assumes a single 50 MHz core clock; included by the timer and top design files.
`ifndef INTC_CONSTS_VH
`define INTC_CONSTS_VH
`define CLK_PERIOD_NS 20
`define TICK_SHORT_NS 128000
`define TICK_LONG_PER_SHORT 8
`define WAKE_PERIOD_NS 1000000
`define PERSIST_TICKS 2
`define CALL_CYCLES 10
`define JMP_CYCLES 5
`define NUM_SRC 11
`define VEC_RESET_ADDR 13'h0000
`define VEC_BASE_ADDR 13'h0002
`define IDX_GLOBAL_EN 8'h20
`define IDX_EP_EN 8'h21
`define IDX_P1_EN 8'h22
`define IDX_P1_POL 8'h23
`define IDX_PENDING 8'h24
`define IDX_USB_MODE 8'h25
`define IDX_CAP_CFG 8'h44
`define IDX_PSC 8'hFF
`define PSC_GIE_BIT 2
`define PSC_WDR_BIT 4
`define PSC_SENSE_BIT 7
`define PSC_WDOG_VALUE 8'h51
`define GIE_BUSRST_BIT 0
`define GIE_T128_BIT 1
`define GIE_T1024_BIT 2
`define GIE_SPI_BIT 3
`define GIE_CAPA_BIT 4
`define GIE_CAPB_BIT 5
`define GIE_GPIO_BIT 6
`define GIE_WAKE_BIT 7
`endif

// ===== verilog/gpio_irq.v
// Port one pin interrupt logic: per-pin enable, edge polarity and lockout.
// Assumes pins are synchronous to clock; emits one-cycle event pulses.
`timescale 1ns/1ps
`default_nettype none
module gpio_irq #(
  parameter PINS = 8
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  input wire soft_clear,
  // Configuration
  input wire gpio_enable,
  input wire [PINS-1:0] pin_enable,
  input wire [PINS-1:0] pin_polarity,
  // Pins and event
  input wire [PINS-1:0] port_one_pins,
  output reg gpio_event
);
  reg [PINS-1:0] prev_reg;
  reg [PINS-1:0] lock_reg;
  wire [PINS-1:0] active = ~(port_one_pins ^ pin_polarity);
  wire [PINS-1:0] edge_hit = (port_one_pins ^ prev_reg) & active & pin_enable;
  // Lock holds while the triggering pin stays active and enabled
  wire locked = |(lock_reg & active & pin_enable);

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      prev_reg <= 8'h00;
      lock_reg <= 8'h00;
      gpio_event <= 1'b0;
    end else if (soft_clear) begin
      prev_reg <= port_one_pins;
      lock_reg <= 8'h00;
      gpio_event <= 1'b0;
    end else begin
      prev_reg <= port_one_pins;
      gpio_event <= 1'b0;
      if (!locked && gpio_enable && |edge_hit) begin
        gpio_event <= 1'b1;
        lock_reg <= edge_hit & ~(edge_hit - 8'h01);
      end else if (!locked) begin
        lock_reg <= 8'h00;
      end
    end
  end
endmodule // gpio_irq
`default_nettype wire

// ===== verilog/periodic_timers.v
// Free-running tick timers, wake-up timer and bus-reset / PS/2 persistence.
// Assumes condition inputs are synchronous levels; outputs are event pulses.
`timescale 1ns/1ps
`default_nettype none
`include "intc_consts.vh"
module periodic_timers #(
  parameter SHORT_CYCLES = 6400,
  parameter WAKE_CYCLES = 50000
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Controls
  input wire wake_enable,
  input wire persist_condition,
  // Events
  output reg tick_short,
  output reg tick_long,
  output reg wake_event,
  output reg persist_event
);
  reg [15:0] short_cnt_reg;
  reg [2:0] long_cnt_reg;
  reg [19:0] wake_cnt_reg;
  reg [1:0] persist_cnt_reg;
  wire short_wrap = short_cnt_reg == SHORT_CYCLES[15:0] - 16'h0001;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      short_cnt_reg <= 16'h0000;
      long_cnt_reg <= 3'h0;
      wake_cnt_reg <= 20'h00000;
      persist_cnt_reg <= 2'h0;
      tick_short <= 1'b0;
      tick_long <= 1'b0;
      wake_event <= 1'b0;
      persist_event <= 1'b0;
    end else begin
      short_cnt_reg <= short_wrap ? 16'h0000 : short_cnt_reg + 16'h0001;
      tick_short <= short_wrap;
      tick_long <= short_wrap && long_cnt_reg == `TICK_LONG_PER_SHORT - 1;
      if (short_wrap)
        long_cnt_reg <= long_cnt_reg + 3'h1;
      // Disabled wake-up timer is held cleared, standing in for power-off
      if (!wake_enable) begin
        wake_cnt_reg <= 20'h00000;
        wake_event <= 1'b0;
      end else begin
        wake_event <= wake_cnt_reg == WAKE_CYCLES[19:0] - 20'h00001;
        wake_cnt_reg <= (wake_cnt_reg == WAKE_CYCLES[19:0] - 20'h00001) ? 20'h00000 : wake_cnt_reg + 20'h00001;
      end
      // Counting short ticks gives the 128 to 256 us window
      persist_event <= 1'b0;
      if (!persist_condition) begin
        persist_cnt_reg <= 2'h0;
      end else if (short_wrap && persist_cnt_reg < `PERSIST_TICKS) begin
        persist_cnt_reg <= persist_cnt_reg + 2'h1;
        persist_event <= persist_cnt_reg == `PERSIST_TICKS - 1;
      end
    end
  end
endmodule // periodic_timers
`default_nettype wire

// ===== verilog/intc_top.v
// Prioritised interrupt controller with Avalon-MM register slave.
// Assumes a core that reports instruction completion and stalls while busy.
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "intc_consts.vh"
module intc_top #(
  parameter SHORT_CYCLES = `TICK_SHORT_NS / `CLK_PERIOD_NS,
  parameter WAKE_CYCLES = `WAKE_PERIOD_NS / `CLK_PERIOD_NS,
  parameter PC_WIDTH = 13
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  input wire wdog_reset,
  // Avalon-MM slave
  input wire [9:0] address,
  input wire read,
  input wire write,
  input wire [3:0] byteenable,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output reg waitrequest,
  // Core instruction status
  input wire instr_done,
  input wire enable_interrupts_instr,
  input wire disable_interrupts_instr,
  input wire return_from_interrupt_instr,
  input wire [PC_WIDTH-1:0] pc_value,
  input wire carry_flag,
  input wire zero_flag,
  input wire [PC_WIDTH-1:0] popped_pc,
  input wire popped_carry_flag,
  input wire popped_zero_flag,
  // Acknowledge sequence to core
  output reg ack_busy,
  output reg push_valid,
  output reg [PC_WIDTH-1:0] push_pc,
  output reg push_carry_flag,
  output reg push_zero_flag,
  output reg vector_valid,
  output reg [PC_WIDTH-1:0] vector_addr,
  output reg routine_start,
  output reg restore_valid,
  output reg [PC_WIDTH-1:0] restore_pc,
  output reg restore_carry_flag,
  output reg restore_zero_flag,
  output reg global_enable,
  output reg irq_sense,
  // Source inputs
  input wire bus_reset_level,
  input wire ps2_activity,
  input wire [2:0] ep_event,
  input wire spi_byte_done,
  input wire transfer_complete_bit,
  input wire capture_a_pin,
  input wire capture_b_pin,
  input wire [7:0] port_one_pins
);
  localparam ST_IDLE = 2'd0;
  localparam ST_CLEAR = 2'd1;
  localparam ST_CALL = 2'd2;
  localparam ST_JUMP = 2'd3;

  // Lowest index wins, so vector 1 has top priority
  function [3:0] pick;
    input [`NUM_SRC-1:0] req;
    integer i;
    begin
      pick = 4'hF;
      for (i = `NUM_SRC - 1; i >= 0; i = i - 1)
        if (req[i])
          pick = i[3:0];
    end
  endfunction

  function [PC_WIDTH-1:0] vec_of;
    input [3:0] idx;
    begin
      vec_of = `VEC_BASE_ADDR + {{(PC_WIDTH-5){1'b0}}, idx, 1'b0};
    end
  endfunction

  reg [7:0] gie_reg;
  reg [2:0] ep_en_reg;
  reg [7:0] p1_en_reg;
  reg [7:0] p1_pol_reg;
  reg [7:0] cap_cfg_reg;
  reg usb_mode_reg;
  reg [7:0] psc_reg;
  reg [`NUM_SRC-1:0] pending_reg;
  reg [`NUM_SRC-1:0] pending_next;
  reg [1:0] state_reg;
  reg [3:0] cnt_reg;
  reg [3:0] winner_reg;
  reg cap_a_prev_reg;
  reg cap_b_prev_reg;
  reg [31:0] read_mux;

  wire tick_short;
  wire tick_long;
  wire wake_event;
  wire persist_event;
  wire gpio_event;
  wire soft_rst = wdog_reset;

  wire [7:0] word_idx = address[9:2];
  wire acc_now = !waitrequest && (read || write);
  wire wr_now = acc_now && write && byteenable[0];

  // Capture edges gated by per-edge enables, one request per pin
  wire cap_a_event = (cap_cfg_reg[0] & capture_a_pin & ~cap_a_prev_reg)
                   | (cap_cfg_reg[1] & ~capture_a_pin & cap_a_prev_reg);
  wire cap_b_event = (cap_cfg_reg[2] & capture_b_pin & ~cap_b_prev_reg)
                   | (cap_cfg_reg[3] & ~capture_b_pin & cap_b_prev_reg);

  wire [`NUM_SRC-1:0] set_vec = {
    wake_event, gpio_event, cap_b_event, cap_a_event,
    spi_byte_done & transfer_complete_bit,
    ep_event, tick_long, tick_short, persist_event};

  wire [`NUM_SRC-1:0] en_vec = {
    gie_reg[`GIE_WAKE_BIT], gie_reg[`GIE_GPIO_BIT], gie_reg[`GIE_CAPB_BIT],
    gie_reg[`GIE_CAPA_BIT], gie_reg[`GIE_SPI_BIT], ep_en_reg,
    gie_reg[`GIE_T1024_BIT], gie_reg[`GIE_T128_BIT], gie_reg[`GIE_BUSRST_BIT]};

  wire [`NUM_SRC-1:0] request = pending_reg & en_vec;
  wire take = state_reg == ST_IDLE && instr_done && global_enable && |request;

  gpio_irq #(
    .PINS(8)
  ) u_gpio (
    .clock(clock),
    .rst(rst),
    .soft_clear(soft_rst),
    .gpio_enable(gie_reg[`GIE_GPIO_BIT]),
    .pin_enable(p1_en_reg),
    .pin_polarity(p1_pol_reg),
    .port_one_pins(port_one_pins),
    .gpio_event(gpio_event)
  );

  periodic_timers #(
    .SHORT_CYCLES(SHORT_CYCLES),
    .WAKE_CYCLES(WAKE_CYCLES)
  ) u_timers (
    .clock(clock),
    .rst(rst),
    .wake_enable(gie_reg[`GIE_WAKE_BIT]),
    .persist_condition(usb_mode_reg ? ps2_activity : bus_reset_level),
    .tick_short(tick_short),
    .tick_long(tick_long),
    .wake_event(wake_event),
    .persist_event(persist_event)
  );

  // Set wins over the acknowledge clear in the same cycle
  always @* begin
    pending_next = pending_reg;
    if (state_reg == ST_CLEAR)
      pending_next[winner_reg] = 1'b0;
    pending_next = pending_next | set_vec;
  end

  always @* begin
    read_mux = 32'h0000_0000;
    case (word_idx)
      `IDX_GLOBAL_EN: read_mux[7:0] = gie_reg;
      `IDX_EP_EN: read_mux[2:0] = ep_en_reg;
      `IDX_P1_EN: read_mux[7:0] = p1_en_reg;
      `IDX_P1_POL: read_mux[7:0] = p1_pol_reg;
      `IDX_PENDING: read_mux[`NUM_SRC-1:0] = pending_reg;
      `IDX_USB_MODE: read_mux[0] = usb_mode_reg;
      `IDX_CAP_CFG: read_mux[7:0] = cap_cfg_reg;
      `IDX_PSC: begin
        read_mux[7:0] = psc_reg;
        read_mux[`PSC_SENSE_BIT] = |pending_reg;
        read_mux[`PSC_GIE_BIT] = global_enable;
      end
      default: read_mux = 32'h0000_0000;
    endcase
  end

  // Bus slave: one wait cycle, answer registered, write lands on the answer edge
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      waitrequest <= 1'b1;
      readdata <= 32'h0000_0000;
    end else begin
      if (acc_now) begin
        waitrequest <= 1'b1;
      end else if (read || write) begin
        waitrequest <= 1'b0;
        readdata <= read ? read_mux : 32'h0000_0000;
      end
    end
  end

  // Software-visible registers
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      gie_reg <= 8'h00;
      ep_en_reg <= 3'h0;
      p1_en_reg <= 8'h00;
      p1_pol_reg <= 8'h00;
      cap_cfg_reg <= 8'h00;
      usb_mode_reg <= 1'b0;
      psc_reg <= 8'h00;
    end else if (soft_rst) begin
      gie_reg <= 8'h00;
      ep_en_reg <= 3'h0;
      p1_en_reg <= 8'h00;
      p1_pol_reg <= 8'h00;
      cap_cfg_reg <= 8'h00;
      usb_mode_reg <= 1'b0;
      psc_reg <= `PSC_WDOG_VALUE;
    end else if (wr_now) begin
      case (word_idx)
        `IDX_GLOBAL_EN: gie_reg <= writedata[7:0];
        `IDX_EP_EN: ep_en_reg <= writedata[2:0];
        `IDX_P1_EN: p1_en_reg <= writedata[7:0];
        `IDX_P1_POL: p1_pol_reg <= writedata[7:0];
        `IDX_CAP_CFG: cap_cfg_reg <= writedata[7:0];
        `IDX_USB_MODE: usb_mode_reg <= writedata[0];
        `IDX_PSC: psc_reg <= writedata[7:0] & 8'h7B;
        default: psc_reg <= psc_reg;
      endcase
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      cap_a_prev_reg <= 1'b0;
      cap_b_prev_reg <= 1'b0;
      pending_reg <= 11'h000;
      irq_sense <= 1'b0;
    end else if (soft_rst) begin
      cap_a_prev_reg <= capture_a_pin;
      cap_b_prev_reg <= capture_b_pin;
      pending_reg <= 11'h000;
      irq_sense <= 1'b0;
    end else begin
      cap_a_prev_reg <= capture_a_pin;
      cap_b_prev_reg <= capture_b_pin;
      pending_reg <= pending_next;
      irq_sense <= |pending_next;
    end
  end

  // Acknowledge sequence and global enable
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      winner_reg <= 4'h0;
      global_enable <= 1'b0;
      ack_busy <= 1'b0;
      push_valid <= 1'b0;
      push_pc <= {PC_WIDTH{1'b0}};
      push_carry_flag <= 1'b0;
      push_zero_flag <= 1'b0;
      vector_valid <= 1'b0;
      vector_addr <= `VEC_RESET_ADDR;
      routine_start <= 1'b0;
      restore_valid <= 1'b0;
      restore_pc <= {PC_WIDTH{1'b0}};
      restore_carry_flag <= 1'b0;
      restore_zero_flag <= 1'b0;
    end else if (soft_rst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      global_enable <= 1'b0;
      ack_busy <= 1'b0;
      push_valid <= 1'b0;
      vector_valid <= 1'b0;
      vector_addr <= `VEC_RESET_ADDR;
      routine_start <= 1'b0;
      restore_valid <= 1'b0;
    end else begin
      push_valid <= 1'b0;
      vector_valid <= 1'b0;
      routine_start <= 1'b0;
      restore_valid <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (take) begin
            global_enable <= 1'b0;
            winner_reg <= pick(request);
            state_reg <= ST_CLEAR;
            cnt_reg <= 4'h1;
            ack_busy <= 1'b1;
          end else if (return_from_interrupt_instr) begin
            global_enable <= 1'b1;
            restore_valid <= 1'b1;
            restore_pc <= popped_pc;
            restore_carry_flag <= popped_carry_flag;
            restore_zero_flag <= popped_zero_flag;
          end else if (enable_interrupts_instr) begin
            global_enable <= 1'b1;
          end else if (disable_interrupts_instr) begin
            global_enable <= 1'b0;
          end
        end
        ST_CLEAR: begin
          // Accumulator is left to the service routine
          push_valid <= 1'b1;
          push_pc <= pc_value;
          push_carry_flag <= carry_flag;
          push_zero_flag <= zero_flag;
          state_reg <= ST_CALL;
          cnt_reg <= cnt_reg + 4'h1;
        end
        ST_CALL: begin
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == `CALL_CYCLES - 1) begin
            vector_valid <= 1'b1;
            vector_addr <= vec_of(winner_reg);
            state_reg <= ST_JUMP;
            cnt_reg <= 4'h1;
          end
        end
        ST_JUMP: begin
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == `JMP_CYCLES) begin
            routine_start <= 1'b1;
            ack_busy <= 1'b0;
            state_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          ack_busy <= 1'b0;
        end
      endcase
    end
  end
endmodule // intc_top
`default_nettype wire

// ===== tb/intc_monitor.sv
// Checker of the acknowledge sequence and the global enable bit.
// Assumes it is bound to intc_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module intc_checker #(
  parameter PC_WIDTH = 13
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic wdog_reset,
  // Core status
  input wire logic instr_done,
  input wire logic enable_interrupts_instr,
  input wire logic disable_interrupts_instr,
  input wire logic return_from_interrupt_instr,
  input wire logic [PC_WIDTH-1:0] pc_value,
  input wire logic carry_flag,
  input wire logic zero_flag,
  input wire logic [PC_WIDTH-1:0] popped_pc,
  input wire logic popped_carry_flag,
  input wire logic popped_zero_flag,
  // Acknowledge outputs
  input wire logic ack_busy,
  input wire logic push_valid,
  input wire logic [PC_WIDTH-1:0] push_pc,
  input wire logic push_carry_flag,
  input wire logic push_zero_flag,
  input wire logic vector_valid,
  input wire logic [PC_WIDTH-1:0] vector_addr,
  input wire logic routine_start,
  input wire logic restore_valid,
  input wire logic [PC_WIDTH-1:0] restore_pc,
  input wire logic restore_carry_flag,
  input wire logic restore_zero_flag,
  input wire logic global_enable
);
  default clocking cb @(posedge clock); endclocking
  // Watchdog aborts a running sequence, so it disables as well
  default disable iff (rst || wdog_reset);
  sequence s_call;
    ##1 push_valid ##8 vector_valid;
  endsequence
  sequence s_jump;
    ##5 (routine_start && !ack_busy);
  endsequence
  a_ack_timing: assert property ($rose(ack_busy) |-> s_call ##0 s_jump)
    else $error("acknowledge steps off their cycles");
  a_ack_after_instr: assert property ($rose(ack_busy) |-> $past(instr_done) && !global_enable)
    else $error("acknowledge started mid instruction or with enable set");
  a_busy_masked: assert property (ack_busy |-> !global_enable)
    else $error("global enable high during acknowledge");
  a_push_state: assert property (push_valid |-> push_pc == pc_value && push_carry_flag == carry_flag
    && push_zero_flag == zero_flag)
    else $error("pushed state differs from core state");
  a_vector_table: assert property (vector_valid |-> vector_addr >= 13'h0002 && vector_addr <= 13'h0016
    && !vector_addr[0])
    else $error("vector outside table");
  a_return_restore: assert property (return_from_interrupt_instr && !ack_busy && !instr_done |=>
    restore_valid && global_enable && restore_pc == $past(popped_pc)
    && restore_carry_flag == $past(popped_carry_flag) && restore_zero_flag == $past(popped_zero_flag))
    else $error("return did not restore state");
  a_enable_sets: assert property (enable_interrupts_instr && !ack_busy && !global_enable |=> global_enable)
    else $error("enable instruction ignored");
  a_disable_clears: assert property (disable_interrupts_instr && !ack_busy |=> !global_enable)
    else $error("disable instruction ignored");
  a_enable_cause: assert property ($rose(global_enable) |->
    $past(enable_interrupts_instr || return_from_interrupt_instr))
    else $error("global enable rose without cause");
endmodule // intc_checker
`default_nettype wire

// ===== tb/core_model.sv
// Behavioural core: runs instructions, stalls on acknowledge, keeps a stack.
// Assumes the controller ports of intc_top; return is commanded by the bench.
`timescale 1ns/1ps
`default_nettype none
module core_model #(
  parameter PC_WIDTH = 13
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Bench controls
  input wire logic slow,
  input wire logic do_ret,
  // From controller
  input wire logic ack_busy,
  input wire logic push_valid,
  input wire logic [PC_WIDTH-1:0] push_pc,
  input wire logic push_carry_flag,
  input wire logic push_zero_flag,
  // To controller
  output logic instr_done,
  output logic return_from_interrupt_instr,
  output logic [PC_WIDTH-1:0] pc_value,
  output logic carry_flag,
  output logic zero_flag,
  output logic [PC_WIDTH-1:0] popped_pc,
  output logic popped_carry_flag,
  output logic popped_zero_flag
);
  logic [PC_WIDTH+1:0] stack [0:7];
  logic [2:0] sp;
  logic [1:0] gap;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      {instr_done, return_from_interrupt_instr, carry_flag, zero_flag} <= 4'h0;
      {popped_pc, popped_carry_flag, popped_zero_flag} <= '0;
      pc_value <= '0;
      sp <= 3'h0;
      gap <= 2'h0;
    end else begin
      instr_done <= 1'b0;
      return_from_interrupt_instr <= 1'b0;
      gap <= gap + 2'h1;
      if (push_valid) begin
        stack[sp] <= {push_pc, push_carry_flag, push_zero_flag};
        sp <= sp + 3'h1;
      end else if (do_ret && !ack_busy) begin
        {popped_pc, popped_carry_flag, popped_zero_flag} <= stack[sp-3'h1];
        sp <= sp - 3'h1;
        return_from_interrupt_instr <= 1'b1;
      end else if (!ack_busy && !instr_done && (!slow || gap == 2'h0)) begin
        // State only moves as an instruction ends, so it is stable while stalled
        instr_done <= 1'b1;
        pc_value <= pc_value + 1'b1;
        carry_flag <= pc_value[0] ^ pc_value[3];
        zero_flag <= pc_value[1];
      end
    end
  end
endmodule // core_model
`default_nettype wire

// ===== tb/prioritized_interrupt_controller_tb.sv
// Self-checking bench of intc_top with a core model and random register data.
// Assumes short timer parameters so every periodic source fires quickly.
`timescale 1ns/1ps
`default_nettype none
module prioritized_interrupt_controller_tb;
  logic clock, rst, wdog_reset, read, write, enable_interrupts_instr, disable_interrupts_instr, do_ret, slow;
  logic bus_reset_level, ps2_activity, spi_byte_done, transfer_complete_bit, capture_a_pin, capture_b_pin;
  logic [9:0] address;
  logic [3:0] byteenable;
  logic [31:0] writedata;
  logic [2:0] ep_event;
  logic [7:0] port_one_pins, r8;
  logic [15:0] rd;
  wire [31:0] readdata;
  wire [12:0] pc_value, popped_pc, push_pc, vector_addr, restore_pc;
  wire waitrequest, instr_done, return_from_interrupt_instr, carry_flag, zero_flag, popped_carry_flag;
  wire popped_zero_flag, ack_busy, push_valid, push_carry_flag, push_zero_flag, vector_valid, routine_start;
  wire restore_valid, restore_carry_flag, restore_zero_flag, global_enable, irq_sense;
  integer mismatches, comparisons, seed, v, i;
  logic [7:0] reg_idx [0:5] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h44, 8'h30};
  intc_top #(.SHORT_CYCLES(16), .WAKE_CYCLES(40)) dut (.clock, .rst, .wdog_reset, .address, .read, .write,
    .byteenable, .writedata, .readdata, .waitrequest, .instr_done, .enable_interrupts_instr,
    .disable_interrupts_instr, .return_from_interrupt_instr, .pc_value, .carry_flag, .zero_flag, .popped_pc,
    .popped_carry_flag, .popped_zero_flag, .ack_busy, .push_valid, .push_pc, .push_carry_flag, .push_zero_flag,
    .vector_valid, .vector_addr, .routine_start, .restore_valid, .restore_pc, .restore_carry_flag,
    .restore_zero_flag, .global_enable, .irq_sense, .bus_reset_level, .ps2_activity, .ep_event, .spi_byte_done,
    .transfer_complete_bit, .capture_a_pin, .capture_b_pin, .port_one_pins);
  core_model core (.clock, .rst, .slow, .do_ret, .ack_busy, .push_valid, .push_pc, .push_carry_flag,
    .push_zero_flag, .instr_done, .return_from_interrupt_instr, .pc_value, .carry_flag, .zero_flag, .popped_pc,
    .popped_carry_flag, .popped_zero_flag);
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  function automatic logic [12:0] vec_exp(input integer n);
    vec_exp = 13'h0002 + 13'(2 * n - 2);
  endfunction
  task test_done;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task check_reg(input logic [15:0] got, input logic [15:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        $display("ERROR at %0t register got %h expected %h", $time, got, exp);
        mismatches = mismatches + 1;
      end
    end
  endtask
  task check_vec(input logic [12:0] got, input logic [12:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        $display("ERROR at %0t vector got %h expected %h", $time, got, exp);
        mismatches = mismatches + 1;
      end
    end
  endtask
  task bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [15:0] q);
    integer n;
    begin
      @(posedge clock);
      address <= {idx, 2'b00};
      writedata <= {24'h0, wd};
      read <= !wr;
      write <= wr;
      n = 0;
      do begin
        @(posedge clock);
        n = n + 1;
      end while (waitrequest !== 1'b0 && n < 50);
      if (n >= 50) begin
        mismatches = mismatches + 1;
        test_done;
      end
      q = readdata[15:0];
      read <= 1'b0;
      write <= 1'b0;
    end
  endtask
  task wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, rd);
  endtask
  task reg_cmp(input logic [7:0] idx, input logic [15:0] mask, input logic [15:0] exp);
    begin
      bus(1'b0, idx, 8'h00, rd);
      check_reg(rd & mask, exp);
    end
  endtask
  task wait_hi(input integer sel);
    integer n;
    begin
      n = 0;
      do begin
        @(posedge clock);
        n = n + 1;
      end while (!(sel == 0 ? vector_valid === 1'b1 : sel == 1 ? routine_start === 1'b1
        : restore_valid === 1'b1) && n < 3000);
      if (n >= 3000) begin
        mismatches = mismatches + 1;
        test_done;
      end
    end
  endtask
  task instr(input logic en);
    begin
      @(posedge clock);
      if (en) enable_interrupts_instr <= 1'b1;
      else disable_interrupts_instr <= 1'b1;
      @(posedge clock);
      enable_interrupts_instr <= 1'b0;
      disable_interrupts_instr <= 1'b0;
    end
  endtask
  task trig(input integer n);
    begin
      @(posedge clock);
      case (n)
        1: bus_reset_level <= 1'b1;
        4, 5, 6: ep_event <= 3'b001 << (n - 4);
        7: {spi_byte_done, transfer_complete_bit} <= 2'b11;
        8: capture_a_pin <= 1'b1;
        9: capture_b_pin <= 1'b1;
        10: port_one_pins[0] <= 1'b1;
        default: ;
      endcase
      @(posedge clock);
      ep_event <= 3'b000;
      spi_byte_done <= 1'b0;
    end
  endtask
  task service(input integer n, input logic clr);
    begin
      wait_hi(0);
      check_vec(vector_addr, vec_exp(n));
      wait_hi(1);
      if (clr) wr(8'h20, 8'h00);
      if (clr) wr(8'h21, 8'h00);
      reg_cmp(8'hFF, 16'h0004, 16'h0000);
      // Periodic sources pend again at once, so their flag is not checked
      if (n != 2 && n != 3 && n != 11) reg_cmp(8'h24, 16'h0001 << (n - 1), 16'h0000);
      @(posedge clock) do_ret <= 1'b1;
      @(posedge clock) do_ret <= 1'b0;
      wait_hi(2);
      if (clr) reg_cmp(8'hFF, 16'h0004, 16'h0004);
    end
  endtask
  initial begin
    seed = 67;
    mismatches = 0;
    comparisons = 0;
    {rst, wdog_reset, read, write, enable_interrupts_instr, disable_interrupts_instr, do_ret, slow} = 8'h80;
    {bus_reset_level, ps2_activity, spi_byte_done, transfer_complete_bit, capture_a_pin, capture_b_pin} = 6'h00;
    address = 10'h000;
    byteenable = 4'h1;
    writedata = 32'h0;
    ep_event = 3'h0;
    port_one_pins = 8'h00;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    for (i = 0; i < 6; i++) reg_cmp(reg_idx[i], 16'hFFFF, 16'h0000);
    reg_cmp(8'hFF, 16'h007F, 16'h0000);
    wr(8'h30, 8'h5A);
    reg_cmp(8'h30, 16'hFFFF, 16'h0000);
    for (i = 0; i < 4; i++) begin
      r8 = $random(seed);
      wr(reg_idx[i], r8);
      reg_cmp(reg_idx[i], 16'hFFFF, {8'h00, i == 1 ? r8 & 8'h07 : r8});
    end
    wr(8'h22, 8'h01);
    wr(8'h23, 8'h01);
    wr(8'h44, 8'h0F);
    $display("test registers done");
    for (v = 1; v <= 11; v++) begin
      slow <= $random(seed);
      instr(1'b0);
      wr(8'h20, v <= 3 ? 8'h01 << (v - 1) : v >= 7 ? 8'h01 << (v - 4) : 8'h00);
      wr(8'h21, v >= 4 && v <= 6 ? 8'h01 << (v - 4) : 8'h00);
      trig(v);
      instr(1'b1);
      service(v, 1'b1);
      {bus_reset_level, capture_a_pin, capture_b_pin, port_one_pins} <= '0;
    end
    $display("test vectors done");
    instr(1'b0);
    wr(8'h21, 8'h05);
    @(posedge clock) ep_event <= 3'b101;
    @(posedge clock) ep_event <= 3'b000;
    reg_cmp(8'hFF, 16'h0084, 16'h0080);
    reg_cmp(8'h24, 16'h0028, 16'h0028);
    check_reg({15'h0000, irq_sense}, 16'h0001);
    instr(1'b1);
    service(4, 1'b0);
    service(6, 1'b1);
    // PS/2 mode selects the other persistence condition
    wr(8'h25, 8'h01);
    wr(8'h20, 8'h01);
    ps2_activity <= 1'b1;
    instr(1'b1);
    service(1, 1'b1);
    ps2_activity <= 1'b0;
    reg_cmp(8'h25, 16'h00FF, 16'h0001);
    $display("test priority done");
    instr(1'b0);
    wr(8'h20, 8'hA5);
    @(posedge clock) wdog_reset <= 1'b1;
    @(posedge clock) wdog_reset <= 1'b0;
    reg_cmp(8'hFF, 16'h007F, 16'h0051);
    reg_cmp(8'h20, 16'h00FF, 16'h0000);
    reg_cmp(8'h22, 16'h00FF, 16'h0000);
    $display("test watchdog done");
    test_done;
  end
endmodule // prioritized_interrupt_controller_tb
bind intc_top intc_checker #(.PC_WIDTH(PC_WIDTH)) chk (.clock, .rst, .wdog_reset, .instr_done,
  .enable_interrupts_instr, .disable_interrupts_instr, .return_from_interrupt_instr, .pc_value, .carry_flag,
  .zero_flag, .popped_pc, .popped_carry_flag, .popped_zero_flag, .ack_busy, .push_valid, .push_pc,
  .push_carry_flag, .push_zero_flag, .vector_valid, .vector_addr, .routine_start, .restore_valid, .restore_pc,
  .restore_carry_flag, .restore_zero_flag, .global_enable);
`default_nettype wire
